// ==== sac_cfg.svh ====
// constants for the stream attribute and clock stamp framer
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
`define SAC_STAMP_W      24
`define SAC_N_ASYNC      24'h008000
`define SAC_FIELD_W      16
`define SAC_SYNC_W       15
`define SAC_STEREO_BAD   2'h2
`define SAC_VBID_FIELD   1
`define SAC_VBID_ILACE   2
`define SAC_ATTR_WORDS   6'h18
`define SAC_SHIFT_MAX    15
`endif

// ==== sac_pkg.sv ====
// types for the stream attribute and clock stamp framer
`default_nettype none
package sac_pkg;
    typedef struct packed {
        logic [15:0] h_total;
        logic [15:0] v_total;
        logic [15:0] h_start;
        logic [15:0] v_start;
        logic        h_pol;
        logic [14:0] h_width;
        logic        v_pol;
        logic [14:0] v_width;
        logic [15:0] h_active;
        logic [15:0] v_active;
    } sac_timing_s;
    typedef struct packed {
        logic       interlaced;
        logic       even_total;
        logic [1:0] stereo;
        logic [2:0] depth;
        logic       colorimetry;
        logic       cea_range;
        logic [1:0] format;
        logic       sync_mode;
    } sac_format_s;
    typedef enum logic [3:0] {
        SAC_IDLE  = 4'h1,
        SAC_OPEN  = 4'h2,
        SAC_BODY  = 4'h4,
        SAC_CLOSE = 4'h8
    } sac_state_e;
endpackage
`default_nettype wire

// ==== sac_mcount.sv ====
// stream clock edge counter over a window of link cycles
`timescale 1ns/10ps
`default_nettype none
`include "sac_cfg.svh"
module sac_mcount
    import sac_pkg::*;
#(
    parameter int W = 24
) (
    input  wire logic         CLOCK,
    input  wire logic         RST,
    input  wire logic         strm_tick,
    input  wire logic [W-1:0] window,
    output logic [W-1:0]      m_value,
    output logic              m_done
);
    logic [W-1:0] link_cnt;
    logic [W-1:0] strm_cnt;
    logic         last;
    if (W < 8) begin : g_bad_width
        $error("window counter too narrow");
    end
    assign last = (link_cnt == window - {{(W-1){1'b0}}, 1'b1});
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            link_cnt <= '0;
            strm_cnt <= '0;
            m_value  <= '0;
            m_done   <= 1'b0;
        end else begin
            m_done <= last;
            if (last) begin
                link_cnt <= '0;
                strm_cnt <= '0;
                m_value  <= strm_cnt + {{(W-1){1'b0}}, strm_tick};
            end else begin
                link_cnt <= link_cnt + {{(W-1){1'b0}}, 1'b1};
                strm_cnt <= strm_cnt + {{(W-1){1'b0}}, strm_tick};
            end
        end
    end
endmodule
`default_nettype wire

// ==== sac_framer.sv ====
// source-side stream attribute framer and video clock stamp generator
//
// Contract
// - M and N are 24-bit values
// - synchronous mode sends fixed M and N
// - asynchronous mode holds N at 8000h
// - M counted over each N-cycle window
// - low M byte sent each line after Vertical_blank_id_byte
// - N and M shifted down together
// - attribute set sent once per frame in blanking
// - totals, starts, actives are 16-bit values
// - sync is polarity bit plus 15-bit width
// - misc zero bit0 marks synchronous clocking
// - misc zero bits 2:1 component format
// - misc zero bit3 range, bit4 colorimetry
// - misc zero bits 7:5 bit depth
// - misc one bit0 even interlaced total
// - misc one stereo code, 10 never sent
// - packet opens with two start symbols
// - Vertical_blank_id_byte bits carry interlace and field
`timescale 1ns/10ps
`default_nettype none
`include "sac_cfg.svh"
module sac_framer
    import sac_pkg::*;
#(
    parameter int SHIFT = 0
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        STRM_TICK,
    input  wire logic [23:0] SYNC_M,
    input  wire logic [23:0] SYNC_N,
    input  wire sac_timing_s TIMING,
    input  wire sac_format_s FORMAT,
    input  wire logic        LINE_BLANK,
    input  wire logic        VBLANK,
    input  wire logic        FIELD_BOTTOM,
    input  wire logic        SEND_ATTR,
    input  wire logic        LINK_READY,
    output logic [7:0]       VBID,
    output logic [7:0]       STAMP_LOW,
    output logic             STAMP_VALID,
    output logic [7:0]       ATTR_BYTE,
    output logic             ATTR_CTRL,
    output logic             ATTR_VALID,
    output logic             ATTR_BUSY,
    output logic [23:0]      M_OUT,
    output logic [23:0]      N_OUT
);
    localparam logic [23:0] N_SHIFTED = `SAC_N_ASYNC >> SHIFT;
    if (SHIFT < 0 || SHIFT > `SAC_SHIFT_MAX) begin : g_bad_shift
        $error("shift out of range");
    end

    sac_state_e   state;
    logic [23:0]  m_meas;
    logic         m_done;
    logic [23:0]  m_cur;
    logic [23:0]  n_cur;
    logic [5:0]   idx;
    logic [7:0]   misc_byte_zero;
    logic [7:0]   misc_byte_one;
    logic [1:0]   stereo_safe;
    logic         sent_frame;
    logic [7:0]   next_byte;
    logic         vblank_d;

    sac_mcount #(.W(`SAC_STAMP_W)) u_count (
        .CLOCK     (CLOCK),
        .RST       (RST),
        .strm_tick (STRM_TICK),
        .window    (N_SHIFTED),
        .m_value   (m_meas),
        .m_done    (m_done)
    );

    // stamps: synchronous fixed, asynchronous N fixed and M measured
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            m_cur <= '0;
            n_cur <= '0;
        end else if (FORMAT.sync_mode) begin
            m_cur <= SYNC_M;
            n_cur <= SYNC_N;
        end else begin
            n_cur <= N_SHIFTED;
            if (m_done) begin
                m_cur <= m_meas;
            end
        end
    end
    assign M_OUT = m_cur;
    assign N_OUT = n_cur;

    assign stereo_safe = (FORMAT.stereo == `SAC_STEREO_BAD) ? 2'h0 : FORMAT.stereo;
    assign misc_byte_zero = {FORMAT.depth, FORMAT.colorimetry, FORMAT.cea_range,
                    FORMAT.format, FORMAT.sync_mode};
    assign misc_byte_one = {5'h00, stereo_safe, FORMAT.interlaced & FORMAT.even_total};

    // per-line blank id and low stamp byte
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            VBID        <= 8'h00;
            STAMP_LOW   <= 8'h00;
            STAMP_VALID <= 1'b0;
        end else begin
            STAMP_VALID <= LINE_BLANK;
            if (LINE_BLANK) begin
                VBID <= {5'h00, FORMAT.interlaced,
                         FORMAT.interlaced & FIELD_BOTTOM, VBLANK};
                STAMP_LOW <= m_cur[7:0];
            end
        end
    end

    // attribute byte sequencer
    always_comb begin
        next_byte = 8'h00;
        case (idx)
            6'h00: next_byte = m_cur[23:16];
            6'h01: next_byte = m_cur[15:8];
            6'h02: next_byte = m_cur[7:0];
            6'h03: next_byte = n_cur[23:16];
            6'h04: next_byte = n_cur[15:8];
            6'h05: next_byte = n_cur[7:0];
            6'h06: next_byte = TIMING.h_total[15:8];
            6'h07: next_byte = TIMING.h_total[7:0];
            6'h08: next_byte = TIMING.v_total[15:8];
            6'h09: next_byte = TIMING.v_total[7:0];
            6'h0A: next_byte = TIMING.h_start[15:8];
            6'h0B: next_byte = TIMING.h_start[7:0];
            6'h0C: next_byte = TIMING.v_start[15:8];
            6'h0D: next_byte = TIMING.v_start[7:0];
            6'h0E: next_byte = {TIMING.h_pol, TIMING.h_width[14:8]};
            6'h0F: next_byte = TIMING.h_width[7:0];
            6'h10: next_byte = {TIMING.v_pol, TIMING.v_width[14:8]};
            6'h11: next_byte = TIMING.v_width[7:0];
            6'h12: next_byte = TIMING.h_active[15:8];
            6'h13: next_byte = TIMING.h_active[7:0];
            6'h14: next_byte = TIMING.v_active[15:8];
            6'h15: next_byte = TIMING.v_active[7:0];
            6'h16: next_byte = misc_byte_zero;
            6'h17: next_byte = misc_byte_one;
            default: next_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            vblank_d <= 1'b0;
        end else begin
            vblank_d <= VBLANK;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state      <= SAC_IDLE;
            idx        <= 6'h00;
            sent_frame <= 1'b0;
            ATTR_BYTE  <= 8'h00;
            ATTR_CTRL  <= 1'b0;
            ATTR_VALID <= 1'b0;
        end else begin
            if (VBLANK && !vblank_d) begin
                sent_frame <= 1'b0;
            end
            case (state)
                SAC_IDLE: begin
                    // the closing symbol stands until the sink takes it
                    if (LINK_READY) begin
                        ATTR_VALID <= 1'b0;
                        ATTR_CTRL  <= 1'b0;
                    end
                    if (VBLANK && SEND_ATTR && !sent_frame && LINK_READY) begin
                        state      <= SAC_OPEN;
                        idx        <= 6'h00;
                        ATTR_CTRL  <= 1'b1;
                        ATTR_VALID <= 1'b1;
                        ATTR_BYTE  <= 8'h00;
                    end
                end
                SAC_OPEN: begin
                    if (LINK_READY) begin
                        state <= SAC_BODY;
                    end
                end
                SAC_BODY: begin
                    if (LINK_READY) begin
                        ATTR_CTRL <= 1'b0;
                        ATTR_BYTE <= next_byte;
                        if (idx == `SAC_ATTR_WORDS - 6'h01) begin
                            state <= SAC_CLOSE;
                        end
                        idx <= idx + 6'h01;
                    end
                end
                SAC_CLOSE: begin
                    if (LINK_READY) begin
                        ATTR_CTRL  <= 1'b1;
                        ATTR_BYTE  <= 8'h00;
                        state      <= SAC_IDLE;
                        sent_frame <= 1'b1;
                    end
                end
                default: state <= SAC_IDLE;
            endcase
        end
    end
    assign ATTR_BUSY = (state != SAC_IDLE);

    stamp_follow_a: assert property (@(posedge CLOCK) disable iff (RST)
        LINE_BLANK |=> STAMP_VALID && STAMP_LOW == $past(m_cur[7:0]))
        else $error("low stamp byte not sent");
    n_async_a: assert property (@(posedge CLOCK) disable iff (RST)
        !FORMAT.sync_mode ##1 !FORMAT.sync_mode |-> n_cur == N_SHIFTED)
        else $error("async N not fixed");
    m_capture_a: assert property (@(posedge CLOCK) disable iff (RST)
        m_done && !FORMAT.sync_mode |=> m_cur == $past(m_meas))
        else $error("measured M not captured");
    m_sync_a: assert property (@(posedge CLOCK) disable iff (RST)
        FORMAT.sync_mode |=> m_cur == $past(SYNC_M))
        else $error("sync M not fixed");
    stereo_code_a: assert property (@(posedge CLOCK) disable iff (RST)
        state == SAC_BODY && LINK_READY && idx == 6'h17 |=>
            ATTR_BYTE[2:1] != `SAC_STEREO_BAD && ATTR_BYTE[7:3] == 5'h00)
        else $error("bad misc one");
    misc_map_a: assert property (@(posedge CLOCK) disable iff (RST)
        state == SAC_BODY && LINK_READY && idx == 6'h16 |=>
            ATTR_BYTE[0] == $past(FORMAT.sync_mode) && ATTR_BYTE[7:5] == $past(FORMAT.depth))
        else $error("misc zero map");
    vbid_prog_a: assert property (@(posedge CLOCK) disable iff (RST)
        LINE_BLANK && !FORMAT.interlaced |=> VBID[2:1] == 2'h0)
        else $error("progressive field bits set");
    once_frame_a: assert property (@(posedge CLOCK) disable iff (RST)
        state == SAC_CLOSE && LINK_READY |=> sent_frame && state == SAC_IDLE)
        else $error("frame send not recorded");
    open_two_a: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(ATTR_BUSY) |-> ATTR_CTRL && ATTR_VALID ##1 ATTR_CTRL)
        else $error("packet does not open with start");
    cov_packet_c: cover property (@(posedge CLOCK) disable iff (RST) state == SAC_CLOSE);
    cov_mdone_c: cover property (@(posedge CLOCK) disable iff (RST) m_done);
    cov_line_c: cover property (@(posedge CLOCK) disable iff (RST) STAMP_VALID);
endmodule
`default_nettype wire

// ==== sac_sink_model.sv ====
// sink-side model: paces the link, captures attribute bytes, rebuilds stamps
`timescale 1ns/10ps
`default_nettype none
module sac_sink_model
    import sac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stall_en,
    input  wire logic [7:0]  attr_byte,
    input  wire logic        attr_ctrl,
    input  wire logic        attr_valid,
    input  wire logic [7:0]  stamp_low,
    input  wire logic        stamp_valid,
    output logic             link_ready,
    output logic [191:0]     rx_bytes,
    output int               ctrl_seen,
    output logic [23:0]      full_stamp,
    output logic             downspread_capable_flag,
    output logic [23:0]      despread_m
);
    logic        pace;
    logic [23:0] rebuilt;
    // pacing by its own ready lets the model take a spread, slowed link
    assign downspread_capable_flag = 1'b1;
    // when stalling, ready drops every other cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pace <= 1'b0;
            link_ready <= 1'b1;
        end else begin
            pace <= ~pace;
            link_ready <= ~stall_en | pace;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_bytes <= '0;
            ctrl_seen <= 0;
        end else if (attr_valid && link_ready) begin
            if (attr_ctrl)
                ctrl_seen <= ctrl_seen + 1;
            else
                rx_bytes <= {rx_bytes[183:0], attr_byte};
        end
    end
    // a smaller low byte than the last one means the stamp carried upward
    assign rebuilt = {full_stamp[23:8] + ((stamp_low < full_stamp[7:0]) ? 16'h1 : 16'h0),
                      stamp_low};
    // averaging successive stamps smooths spread out of the regenerated rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            full_stamp <= '0;
            despread_m <= '0;
        end else if (stamp_valid) begin
            full_stamp <= rebuilt;
            despread_m <= 24'((25'(despread_m) + 25'(rebuilt)) >> 1);
        end
    end
endmodule
`default_nettype wire

// ==== stream_attribute_and_clock_stamp_tb.sv ====
// self-checking bench for the stream attribute framer
`timescale 1ns/10ps
`default_nettype none
module stream_attribute_and_clock_stamp_tb
    import sac_pkg::*;
;
    logic CLOCK, RST, STRM_TICK, LINE_BLANK, VBLANK, FIELD_BOTTOM, SEND_ATTR, LINK_READY;
    logic [23:0] SYNC_M, SYNC_N, M_OUT, N_OUT, full_stamp, despread_m;
    sac_timing_s TIMING;
    sac_format_s FORMAT;
    logic [7:0] VBID, STAMP_LOW, ATTR_BYTE;
    logic [7:0] t = 8'h00;
    logic STAMP_VALID, ATTR_CTRL, ATTR_VALID, ATTR_BUSY, stall, downspread_flag;
    logic [191:0] rx_bytes;
    int ctrl_seen, num_errors, check_count, c1;
    logic [2:0] st;
    sac_framer #(.SHIFT(8)) dut_u (.CLOCK(CLOCK), .RST(RST), .STRM_TICK(STRM_TICK),
        .SYNC_M(SYNC_M), .SYNC_N(SYNC_N), .TIMING(TIMING), .FORMAT(FORMAT),
        .LINE_BLANK(LINE_BLANK), .VBLANK(VBLANK), .FIELD_BOTTOM(FIELD_BOTTOM),
        .SEND_ATTR(SEND_ATTR), .LINK_READY(LINK_READY), .VBID(VBID), .STAMP_LOW(STAMP_LOW),
        .STAMP_VALID(STAMP_VALID), .ATTR_BYTE(ATTR_BYTE), .ATTR_CTRL(ATTR_CTRL),
        .ATTR_VALID(ATTR_VALID), .ATTR_BUSY(ATTR_BUSY), .M_OUT(M_OUT), .N_OUT(N_OUT));
    sac_sink_model sink_u (.clk(CLOCK), .rst(RST), .stall_en(stall), .attr_byte(ATTR_BYTE),
        .attr_ctrl(ATTR_CTRL), .attr_valid(ATTR_VALID), .stamp_low(STAMP_LOW),
        .stamp_valid(STAMP_VALID), .link_ready(LINK_READY), .rx_bytes(rx_bytes),
        .ctrl_seen(ctrl_seen), .full_stamp(full_stamp),
        .downspread_capable_flag(downspread_flag), .despread_m(despread_m));
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    // stream ticks on three of every four link cycles
    always @(posedge CLOCK) begin
        t <= t + 8'h1;
        STRM_TICK <= (t[1:0] != 2'h3);
    end
    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one vertical blank: expect one packet, then nothing more in the same blank
    task automatic frame(input logic [191:0] exp);
        int c0;
        int n;
        c0 = ctrl_seen;
        VBLANK <= 1'b1;
        repeat (4) @(posedge CLOCK);
        for (n = 0; n < 200 && ATTR_BUSY === 1'b1; n++) @(posedge CLOCK);
        repeat (3) @(posedge CLOCK);
        check(rx_bytes, exp);
        check(ctrl_seen - c0, 3);
        repeat (40) @(posedge CLOCK);
        check(ctrl_seen - c0, 3);
        VBLANK <= 1'b0;
        repeat (4) @(posedge CLOCK);
    endtask
    task automatic line_stamp(input logic [7:0] exp_low);
        LINE_BLANK <= 1'b1;
        @(posedge CLOCK);
        LINE_BLANK <= 1'b0;
        @(posedge CLOCK);
        check(STAMP_VALID, 1'b1);
        check(STAMP_LOW, exp_low);
        @(posedge CLOCK);
        check(STAMP_VALID, 1'b0);
    endtask
    initial begin
        {RST, LINE_BLANK, VBLANK, FIELD_BOTTOM, stall} = {1'b1, 4'h0};
        {num_errors, check_count} = 0;
        SEND_ATTR = 1'b1;
        SYNC_M = 24'h1234C6;
        SYNC_N = 24'h00ABCD;
        TIMING = 128'h0672_0326_0104_0019_802C_0005_0556_0300;
        FORMAT = 12'h001;
        repeat (12) @(posedge CLOCK);
        check({VBID, ATTR_VALID, M_OUT}, 0);
        RST <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            st = 3'(i);
            stall <= (i == 1);
            // odd passes mark an interlaced frame with an even line total
            FORMAT <= {st[0], st[0], st[1:0], st, ~st[0], st[0], st[1:0], 1'b1};
            @(posedge CLOCK);
            // stereo code 10 is never sent; bits 7:3 of misc one stay zero
            frame({SYNC_M, SYNC_N, TIMING, FORMAT[7:0], 5'h0,
                   (st == 3'h2) ? 2'h0 : st[1:0], st[0]});
        end
        stall <= 1'b0;
        repeat (300) @(posedge CLOCK);
        check({M_OUT, N_OUT}, {SYNC_M, SYNC_N});
        line_stamp(SYNC_M[7:0]);
        check(full_stamp, {16'h0000, SYNC_M[7:0]});
        // a blank with sending disabled must carry no packet
        c1 = ctrl_seen;
        SEND_ATTR <= 1'b0;
        FORMAT <= 12'hC00;
        FIELD_BOTTOM <= 1'b1;
        VBLANK <= 1'b1;
        repeat (300) @(posedge CLOCK);
        line_stamp(8'h60);
        check(VBID, 8'h07);
        check(full_stamp, 24'h000160);
        FIELD_BOTTOM <= 1'b0;
        line_stamp(8'h60);
        check(VBID, 8'h05);
        check(ctrl_seen - c1, 0);
        SEND_ATTR <= 1'b1;
        VBLANK <= 1'b0;
        FORMAT <= 12'h000;
        repeat (300) @(posedge CLOCK);
        line_stamp(8'h60);
        check(VBID, 8'h00);
        check(N_OUT, 24'h000080);
        check(M_OUT, 24'h000060);
        check(full_stamp, 24'h000160);
        check(downspread_flag, 1'b1);
        check(despread_m, 24'h000140);
        frame({24'h000060, 24'h000080, TIMING, 16'h0000});
        give_verdict();
    end
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
